// *** common/dio_select_defs.svh ***
// Offsets, field positions, reset values and timing counts of the digital I/O selector.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DIO_SELECT_DEFS_SVH
`define DIO_SELECT_DEFS_SVH

// Register byte offsets
`define OFS_OUT_ONE_CFG    12'h000
`define OFS_OUT_TWO_CFG    12'h004
`define OFS_IN_CFG         12'h008
`define OFS_EDIT           12'h00c
`define OFS_STATUS         12'h010

// Output config fields: function [3:0], polarity [4]
`define FLD_OUT_FUNC_LSB   0
`define FLD_OUT_POL_BIT    4
// Input config fields: function [2:0], level [3]
`define FLD_IN_FUNC_LSB    0
`define FLD_IN_LVL_BIT     3
// Edit register: target [1:0], command [5:4], tentative value [12:8]
`define FLD_EDIT_TGT_LSB   0
`define FLD_EDIT_CMD_LSB   4
`define FLD_EDIT_VAL_LSB   8

// Edit commands
`define CMD_HOLD           2'h1
`define CMD_ACCEPT         2'h2
`define CMD_REJECT         2'h3
`define CMD_ABANDON        2'h0

// Reset values
`define RST_OUT_CFG        5'h00
`define RST_IN_CFG         4'h0

// Debounce time of the digital input, in us, and its count at 250 MHz
`define DEBOUNCE_US        1000
`define CLK_MHZ            250
`define DEBOUNCE_CYCLES    (`DEBOUNCE_US * `CLK_MHZ)

`endif

// *** common/dio_select_pkg.sv ***
// Types of the digital I/O selector: function codes, edit states, carriers.
// Assumes dio_select_defs.svh sits in the include path.
`include "dio_select_defs.svh"

package dio_select_pkg;

    // Output functions, in selection order
    typedef enum logic [3:0] {
        OF_UNUSED, OF_HIGH, OF_LOW, OF_HIGH_HIGH, OF_LOW_LOW, OF_PIPE_VOID,
        OF_RANGE_ONE, OF_RANGE_TWO, OF_PRESET, OF_CONV_FAIL, OF_PULSE,
        OF_PULSE_FWD, OF_PULSE_REV, OF_MR_HIGH, OF_MR_LOW
    } out_func_t;

    // Input functions, in selection order
    typedef enum logic [2:0] {
        IF_UNUSED, IF_RUN_HALT, IF_CLEAR_RUN, IF_RANGE_SEL, IF_ZEROING, IF_FIXED_OUT
    } in_func_t;

    // Edit sequence states
    typedef enum logic [1:0] {
        ED_IDLE, ED_EDITING, ED_CONFIRM
    } edit_state_t;

    // Output configuration
    typedef struct packed {
        logic      closed_when_normal;
        out_func_t func;
    } out_cfg_t;

    // Input configuration
    typedef struct packed {
        logic     high_level;
        in_func_t func;
    } in_cfg_t;

    // Conditions arriving from the measurement core
    typedef struct packed {
        logic high_alarm;
        logic low_alarm;
        logic high_high_alarm;
        logic low_low_alarm;
        logic pipe_void;
        logic range_one;
        logic range_two;
        logic preset_count;
        logic converter_failure;
        logic multirange_high;
        logic multirange_low;
        logic pulse_fwd;
        logic pulse_rev;
        logic multi_range_type;
    } conditions_t;

    // Controls to the totalizer, range, zeroing and fixed-output logic
    typedef struct packed {
        logic totalizer_run;
        logic totalizer_clear;
        logic range_select;
        logic zeroing_start;
        logic fixed_output;
    } in_controls_t;

endpackage

// *** logic/dio_select.sv ***
// Digital output source selector and digital input function decoder, APB slave.
// Assumes a 250 MHz pclk, input conditions synchronous to pclk, and a raw field input.
//
// Function
// R1 - Each contact output selects one of fifteen functions.
// R2 - Contact polarity applies only to alarm functions.
// R3 - Closed-when-normal: contact closed without alarm, open during alarm.
// R4 - Open-when-normal: contact open without alarm, closed during alarm.
// R5 - General pulse carries both directions under multi-range forward/reverse type.
// R6 - Fixed forward and fixed reverse pulses carry only their own direction.
// R7 - Converter failure function follows the internal failure report.
// R8 - Pipe-void function follows empty pipe detection.
// R9 - Multi-range high and low functions follow their conditions.
// R10 - Input takes one of six functions.
// R11 - Zeroing function starts still-water zero on input activation.
// R12 - Detection level matters only for the two totalizer functions.
// R13 - Low level, run/halt: high halts, low runs.
// R14 - Low level, clear/run: high runs, low clears.
// R15 - High level, run/halt: high runs, low halts.
// R16 - High level, clear/run: high clears, low runs.
// R17 - Accepted scroll value is held tentative; active setting unchanged.
// R18 - Confirm: accept commits, reject re-edits, abandon drops and exits.
// R19 - Unused output stays inactive; unused input is ignored.
// R20 - Input is synchronised and debounced before use.
`timescale 1ns/1ps
`default_nettype none
`include "dio_select_defs.svh"

module dio_select #(
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Measurement conditions
    input  wire dio_select_pkg::conditions_t  cond,
    // Field contact input
    input  wire logic                         field_input,
    // Contact outputs, high means contact closed
    output logic                              contact_output_one,
    output logic                              contact_output_two,
    // Controls to the measurement core
    output dio_select_pkg::in_controls_t      controls
);

    //==========================================================
    // Functions
    //==========================================================

    // Raw activity of a function, before polarity
    function automatic logic source_of(input dio_select_pkg::out_func_t f,
                                       input dio_select_pkg::conditions_t c);
        logic s;
        s = 1'b0;
        case (f)
            dio_select_pkg::OF_HIGH:      s = c.high_alarm;
            dio_select_pkg::OF_LOW:       s = c.low_alarm;
            dio_select_pkg::OF_HIGH_HIGH: s = c.high_high_alarm;
            dio_select_pkg::OF_LOW_LOW:   s = c.low_low_alarm;
            dio_select_pkg::OF_PIPE_VOID: s = c.pipe_void;                 // [R8]
            dio_select_pkg::OF_RANGE_ONE: s = c.range_one;
            dio_select_pkg::OF_RANGE_TWO: s = c.range_two;
            dio_select_pkg::OF_PRESET:    s = c.preset_count;
            dio_select_pkg::OF_CONV_FAIL: s = c.converter_failure;         // [R7]
            // Without multi-range type only forward pulses exist
            dio_select_pkg::OF_PULSE:     s = c.pulse_fwd | (c.multi_range_type & c.pulse_rev); // [R5]
            dio_select_pkg::OF_PULSE_FWD: s = c.pulse_fwd;                 // [R6]
            dio_select_pkg::OF_PULSE_REV: s = c.pulse_rev;                 // [R6]
            dio_select_pkg::OF_MR_HIGH:   s = c.multirange_high;           // [R9]
            dio_select_pkg::OF_MR_LOW:    s = c.multirange_low;            // [R9]
            default:                      s = 1'b0;                        // [R19]
        endcase
        return s;
    endfunction

    // True for the alarm functions that honour polarity
    function automatic logic is_alarm(input dio_select_pkg::out_func_t f);
        logic a;
        a = 1'b0;
        case (f)
            dio_select_pkg::OF_HIGH, dio_select_pkg::OF_LOW, dio_select_pkg::OF_HIGH_HIGH,
            dio_select_pkg::OF_LOW_LOW, dio_select_pkg::OF_PIPE_VOID, dio_select_pkg::OF_CONV_FAIL,
            dio_select_pkg::OF_MR_HIGH, dio_select_pkg::OF_MR_LOW: a = 1'b1;
            default: a = 1'b0;
        endcase
        return a;
    endfunction

    // Contact level for one output: closed is 1
    function automatic logic contact_of(input dio_select_pkg::out_cfg_t cfg,
                                        input dio_select_pkg::conditions_t c);
        logic s;
        logic k;
        s = source_of(cfg.func, c);                                        // [R1]
        k = s;
        if (cfg.func == dio_select_pkg::OF_UNUSED) begin
            k = 1'b0;                                                      // [R19]
        end else if (is_alarm(cfg.func)) begin                             // [R2]
            // Closed-when-normal opens on alarm, open-when-normal closes on it
            k = cfg.closed_when_normal ? ~s : s;                           // [R3] [R4]
        end
        return k;
    endfunction

    //==========================================================
    // Configuration and edit state
    //==========================================================

    dio_select_pkg::out_cfg_t    out_one_reg;
    dio_select_pkg::out_cfg_t    out_two_reg;
    dio_select_pkg::in_cfg_t     in_reg;
    dio_select_pkg::edit_state_t edit_reg;
    logic [1:0]                  target_reg;
    logic [4:0]                  tentative_reg;

    logic       wr_en;
    logic       rd_en;
    logic       addr_ok;
    logic [1:0] cmd;

    assign wr_en   = psel & penable & pwrite & pready;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == `OFS_OUT_ONE_CFG) | (paddr == `OFS_OUT_TWO_CFG) |
                     (paddr == `OFS_IN_CFG) | (paddr == `OFS_EDIT) | (paddr == `OFS_STATUS);
    assign cmd     = pwdata[`FLD_EDIT_CMD_LSB +: 2];

    // Edit sequence: hold tentative, confirm, commit or drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edit_reg      <= dio_select_pkg::ED_IDLE;
            target_reg    <= 2'h0;
            tentative_reg <= 5'h00;
        end else if (wr_en && paddr == `OFS_EDIT) begin
            case (cmd)
                `CMD_HOLD: begin
                    // Only the tentative value moves; active setting stays
                    if (edit_reg != dio_select_pkg::ED_CONFIRM) begin  // [R17]
                        target_reg    <= pwdata[`FLD_EDIT_TGT_LSB +: 2];
                        tentative_reg <= pwdata[`FLD_EDIT_VAL_LSB +: 5];
                        edit_reg      <= dio_select_pkg::ED_CONFIRM;
                    end
                end
                `CMD_REJECT: begin
                    if (edit_reg == dio_select_pkg::ED_CONFIRM) begin
                        edit_reg <= dio_select_pkg::ED_EDITING;           // [R18]
                    end
                end
                `CMD_ACCEPT: begin
                    if (edit_reg == dio_select_pkg::ED_CONFIRM) begin
                        edit_reg <= dio_select_pkg::ED_IDLE;              // [R18]
                    end
                end
                default: begin
                    edit_reg <= dio_select_pkg::ED_IDLE;                  // [R18]
                end
            endcase
        end
    end

    logic commit;
    assign commit = wr_en && paddr == `OFS_EDIT && cmd == `CMD_ACCEPT &&
                    edit_reg == dio_select_pkg::ED_CONFIRM;

    // Active configuration changes only on a confirmed commit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_one_reg <= dio_select_pkg::out_cfg_t'(`RST_OUT_CFG);
            out_two_reg <= dio_select_pkg::out_cfg_t'(`RST_OUT_CFG);
            in_reg      <= dio_select_pkg::in_cfg_t'(`RST_IN_CFG);
        end else if (commit) begin                                     // [R18]
            case (target_reg)
                2'h0: out_one_reg <= dio_select_pkg::out_cfg_t'(tentative_reg);
                2'h1: out_two_reg <= dio_select_pkg::out_cfg_t'(tentative_reg);
                2'h2: in_reg      <= dio_select_pkg::in_cfg_t'(tentative_reg[3:0]);
                default: ;
            endcase
        end
    end

    //==========================================================
    // APB read path
    //==========================================================

    logic [31:0] rd_value;

    // Field input conditioning state, declared here because the status read uses it
    logic        sync_a_reg;
    logic        sync_b_reg;
    logic        in_level_reg;
    logic        in_prev_reg;
    logic [31:0] bounce_cnt_reg;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_value = 32'h0000_0000;
        case (paddr)
            `OFS_OUT_ONE_CFG: rd_value = {27'h0, out_one_reg};
            `OFS_OUT_TWO_CFG: rd_value = {27'h0, out_two_reg};
            `OFS_IN_CFG:      rd_value = {28'h0, in_reg};
            `OFS_EDIT:        rd_value = {19'h0, tentative_reg, 2'h0, edit_reg, 2'h0, target_reg};
            `OFS_STATUS:      rd_value = {25'h0, in_level_reg, contact_output_two,
                                          contact_output_one, 1'b0, controls[2:0]};
            default:          rd_value = 32'h0000_0000;
        endcase
    end

    // No wait state: ready in every access phase, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (rd_en) begin
                prdata <= rd_value;
            end
        end
    end

    //==========================================================
    // Field input conditioning
    //==========================================================

    // Two-stage synchroniser then a stable-for-N filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a_reg     <= 1'b0;
            sync_b_reg     <= 1'b0;
            in_level_reg   <= 1'b0;
            bounce_cnt_reg <= 32'h0000_0000;
        end else begin
            sync_a_reg <= field_input;                                     // [R20]
            sync_b_reg <= sync_a_reg;
            if (sync_b_reg == in_level_reg) begin
                bounce_cnt_reg <= 32'h0000_0000;
            end else if (bounce_cnt_reg >= DEBOUNCE_CYCLES - 1) begin
                in_level_reg   <= sync_b_reg;                              // [R20]
                bounce_cnt_reg <= 32'h0000_0000;
            end else begin
                bounce_cnt_reg <= bounce_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Previous filtered level, for the zeroing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_prev_reg <= 1'b0;
        end else begin
            in_prev_reg <= in_level_reg;
        end
    end

    //==========================================================
    // Input function decode
    //==========================================================

    dio_select_pkg::in_controls_t ctl_next;

    // Level applies to totalizer functions only; others use active-high
    always_comb begin
        ctl_next = '0;
        ctl_next.totalizer_run = 1'b1;
        case (in_reg.func)                                                 // [R10]
            dio_select_pkg::IF_RUN_HALT: begin                             // [R12]
                ctl_next.totalizer_run = in_reg.high_level ? in_level_reg : ~in_level_reg; // [R13] [R15]
            end
            dio_select_pkg::IF_CLEAR_RUN: begin                            // [R12]
                ctl_next.totalizer_clear = in_reg.high_level ? in_level_reg : ~in_level_reg; // [R14] [R16]
                ctl_next.totalizer_run   = ~ctl_next.totalizer_clear;
            end
            dio_select_pkg::IF_RANGE_SEL: ctl_next.range_select = in_level_reg;
            dio_select_pkg::IF_ZEROING:   ctl_next.zeroing_start = in_level_reg & ~in_prev_reg; // [R11]
            dio_select_pkg::IF_FIXED_OUT: ctl_next.fixed_output = in_level_reg;
            default: ;                                                     // [R19]
        endcase
    end

    //==========================================================
    // Registered outputs
    //==========================================================

    // Contacts and controls come straight from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contact_output_one <= 1'b0;
            contact_output_two <= 1'b0;
            controls           <= '0;
        end else begin
            contact_output_one <= contact_of(out_one_reg, cond);
            contact_output_two <= contact_of(out_two_reg, cond);
            controls           <= ctl_next;
        end
    end

endmodule
`default_nettype wire

// *** tb/dio_select_asserts.sv ***
// Checker of the digital I/O selector, watching top-level ports only.
// Assumes the bench binds it and DEBOUNCE_CYCLES is at least 4.
`timescale 1ns/1ps
`default_nettype none
module dio_select_asserts #(
    parameter int unsigned DEBOUNCE_CYCLES = 4
) (
    // Clock and reset
    input wire logic                         pclk,
    input wire logic                         presetn,
    // APB
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic [11:0]                  paddr,
    input wire logic                         pready,
    input wire logic                         pslverr,
    // Field side
    input wire logic                         field_input,
    input wire dio_select_pkg::in_controls_t controls
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ======
    // Steps of an APB cycle and a settled low input
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence input_low;
        (!field_input) [*8];
    endsequence

    // ======
    // Bus handshake
    setup_ready_a: assert property (apb_setup |=> pready) else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    unmapped_err_a: assert property (apb_setup ##0 (paddr > 12'h010) |=> pslverr) else $error("no error");

    // ======
    // Input controls; no filtered level rises just after a settled input low
    zero_pulse_a: assert property ($rose(controls.zeroing_start) |=> !controls.zeroing_start)
        else $error("zeroing start not a pulse");
    run_clear_a: assert property (controls.totalizer_clear |-> !controls.totalizer_run)
        else $error("run during clear");
    range_filter_a: assert property (input_low |-> ##3 (!$rose(controls.range_select)) [*4])
        else $error("range select glitch");
    fixed_filter_a: assert property (input_low |-> ##3 (!$rose(controls.fixed_output)) [*4])
        else $error("fixed output glitch");
endmodule
`default_nettype wire

// *** tb/field_contact.sv ***
// Field contact model: bounces on every change before it settles.
// Assumes bounce runs shorter than the design's debounce count.
`timescale 1ns/1ps
`default_nettype none
module field_contact (
    // Clock
    input wire logic  pclk,
    // Requested contact level
    input wire logic  level_req,
    // Wire to the design
    output var logic  field_input
);
    logic settled = 1'b0;
    int   cnt = 0;

    // ======
    // Toggle for two cycles after a change, a real contact is never clean
    initial field_input = 1'b0;
    always @(posedge pclk) begin
        if (level_req !== settled) begin
            settled <= level_req;
            cnt <= 3;
            field_input <= level_req;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            field_input <= (cnt == 1) ? settled : ~field_input;
        end
    end
endmodule
`default_nettype wire

// *** tb/dio_select_tb.sv ***
// Bench of the digital I/O selector: APB driver, reference model, field contact.
// Assumes the checker and field contact model compile before it.
`timescale 1ns/1ps
`default_nettype none
module dio_select_tb;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, level_req, field_input, rerr;
    logic        contact_output_one, contact_output_two;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    dio_select_pkg::conditions_t  cond;
    dio_select_pkg::in_controls_t controls;
    int          fail_count = 0, n_compared = 0, seed = 58, zero_seen = 0, exp_zero = 0;

    dio_select #(.DEBOUNCE_CYCLES(4)) i_dio_select (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cond, .field_input, .contact_output_one,
        .contact_output_two, .controls);
    field_contact i_field_contact (.pclk, .level_req, .field_input);

    // ======
    // Clock and zeroing pulse counter
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        if (controls.zeroing_start === 1'b1) zero_seen <= zero_seen + 1;
    end

    // ======
    // Reference model: source per function, inversion only for alarms
    function automatic logic exp_contact(input logic [4:0] cfg, input dio_select_pkg::conditions_t c);
        logic [14:0] src;
        src = {c.multirange_low, c.multirange_high, c.pulse_rev, c.pulse_fwd,
               c.pulse_fwd | (c.multi_range_type & c.pulse_rev), c.converter_failure, c.preset_count,
               c.range_two, c.range_one, c.pipe_void, c.low_low_alarm, c.high_high_alarm, c.low_alarm,
               c.high_alarm, 1'b0};
        return src[cfg[3:0]] ^ (cfg[4] & (16'h623e >> cfg[3:0]));
    endfunction
    // Expected {run, clear, range, fixed} for a config and settled level
    function automatic logic [3:0] exp_ctrl(input logic [3:0] cfg, input logic lv);
        logic act;
        act = cfg[3] ? lv : !lv;
        case (cfg[2:0])
            3'h1: return {act, 3'b000};
            3'h2: return {!act, act, 2'b00};
            3'h3: return {2'b10, lv, 1'b0};
            3'h5: return {3'b100, lv};
            default: return 4'b1000;
        endcase
    endfunction

    // ======
    // Shared tasks
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Look at pready while it settles mid-cycle, then act on the edge that samples it
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic edit(input logic [1:0] t, input logic [1:0] c, input logic [4:0] v);
        apb(1'b1, 12'h00c, {19'h0, v, 2'h0, c, 2'h0, t});
    endtask
    task automatic commit(input logic [1:0] t, input logic [4:0] v);
        edit(t, 2'h1, v);
        edit(t, 2'h2, v);
    endtask

    // ======
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, level_req} = '0;
        cond = '1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        check(32'(contact_output_one), 32'h0);
        edit(2'h0, 2'h1, 5'h01);
        apb(1'b0, 12'h00c, 32'h0);
        check(rdata, 32'h0000_0120);
        check(32'(contact_output_one), 32'h0);
        edit(2'h0, 2'h3, 5'h01);
        apb(1'b0, 12'h00c, 32'h0);
        check(32'(rdata[5:4]), 32'h1);
        edit(2'h0, 2'h1, 5'h01);
        edit(2'h0, 2'h0, 5'h01);
        apb(1'b0, 12'h00c, 32'h0);
        check(32'(rdata[5:4]), 32'h0);
        check(32'(contact_output_one), 32'h0);
        commit(2'h0, 5'h01);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        check({31'h0, rerr}, 32'h1);
        check(rdata, 32'h0);
        check(32'(contact_output_one), 32'h1);
        for (int f = 0; f < 15; f++) begin
            for (int p = 0; p < 2; p++) begin
                commit(2'h0, {p[0], f[3:0]});
                commit(2'h1, {p[0], 4'(14 - f)});
                repeat (4) begin
                    cond <= 14'($random(seed));
                    repeat (3) @(posedge pclk);
                    check(32'(contact_output_one), 32'(exp_contact({p[0], f[3:0]}, cond)));
                    check(32'(contact_output_two), 32'(exp_contact({p[0], 4'(14 - f)}, cond)));
                end
                apb(1'b0, 12'h010, 32'h0);
                check(32'(rdata[5:4]), 32'({contact_output_two, contact_output_one}));
            end
        end
        for (int f = 0; f < 6; f++) begin
            for (int h = 0; h < 2; h++) begin
                level_req <= 1'b0;
                repeat (16) @(posedge pclk);
                commit(2'h2, {1'b0, h[0], f[2:0]});
                for (int k = 0; k < 3; k++) begin
                    level_req <= ~k[0];
                    if (f == 4 && k != 1) exp_zero++;
                    repeat (16) @(posedge pclk);
                    check(32'({controls.totalizer_run, controls.totalizer_clear, controls.range_select,
                        controls.fixed_output}), 32'(exp_ctrl({h[0], f[2:0]}, ~k[0])));
                    check(32'(zero_seen), 32'(exp_zero));
                end
                apb(1'b0, 12'h010, 32'h0);
                check(32'(rdata[6]), 32'h1);
            end
        end
        finish_test();
    end
endmodule

bind dio_select dio_select_asserts #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) i_dio_select_asserts (.pclk,
    .presetn, .psel, .penable, .paddr, .pready, .pslverr, .field_input, .controls);
`default_nettype wire
